// file: common/odpc_pkg.sv
// Constants, register map and field layout of the output disable and power control bank
//
// Function
// - Bits 2-5 three-state green/blue byte lanes
// - Bits 6 or 7 three-state pixel clock
// - Disable bits override every other output setting
// - Power bit 0 powers down red converter
// - Power bit 1 powers down green converter
// - Power bit 2 powers down blue converter
// - Power bit 3 powers down sampling loop
// - Clamp impedance code in bits 6:4, 0 off
// - Sampling loop offers 64 phase positions
// - Loop needs pixels per line programmed and power bit 3 clear
package odpc_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8; // Register address width
    localparam int DATA_W = 8; // Register data width
    localparam int LANES = 6; // Byte lanes: RP, RS, GP, GS, BP, BS
    localparam int BYTE_W = 8; // Bits per lane
    localparam int PHASE_STEPS = 64; // Sample positions per pixel
    localparam int PHASE_W = $clog2(PHASE_STEPS); // Phase select width
    localparam int PPL_W = 12; // Pixels-per-line width

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TRISTATE = 8'h1A; // output_tristate_control
    localparam logic [7:0] OFS_POWER = 8'h1B; // converter_power_down
    localparam logic [7:0] OFS_TUNING = 8'h1C; // video_tuning
    localparam logic [7:0] OFS_CLAMP = 8'h23; // restore_clamp_impedance
    localparam logic [7:0] OFS_PPL_LO = 8'h30; // Pixels per line, low byte
    localparam logic [7:0] OFS_PPL_HI = 8'h31; // Pixels per line, high nibble
    localparam logic [7:0] OFS_PHASE = 8'h32; // Sampling phase select
    localparam logic [7:0] OFS_STATUS = 8'h33; // Read-only block state

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TRISTATE = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_TUNING = 8'h47;
    localparam logic [7:0] RST_CLAMP = 8'h08;
    localparam logic [7:0] RST_PPL_LO = 8'h00;
    localparam logic [7:0] RST_PPL_HI = 8'h00;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] TUNING_BEST = 8'h49; // Recommended broadcast setting

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int TS_LANE_LSB = 0; // Lane disables start at bit 0
    localparam int TS_CLK_A = 6; // Pixel clock disable, first copy
    localparam int TS_CLK_B = 7; // Pixel clock disable, second copy
    localparam int PD_RED = 0;
    localparam int PD_GREEN = 1;
    localparam int PD_BLUE = 2;
    localparam int PD_LOOP = 3;
    localparam logic [7:0] PD_MASK = 8'h0F; // Bits 7:4 reserved
    localparam int CLAMP_LSB = 4; // Impedance code bits 6:4
    localparam int CLAMP_W = 3;
    localparam logic [7:0] CLAMP_MASK = 8'h7F; // Bit 7 reserved
    localparam logic [7:0] PPL_HI_MASK = 8'h0F; // Upper pixel-count bits
    localparam logic [7:0] PHASE_MASK = 8'h3F; // Phase select bits
    localparam int ST_LOOP_RUN = 0; // Status: loop running
    localparam int ST_CLAMP_ON = 1; // Status: clamp connected
    localparam int ST_LANE_OFF = 2; // Status: some lane three-stated
    localparam int ST_CLK_OFF = 3; // Status: pixel clock three-stated

    // ------------------------------------------------------------
    // Loop range and clock
    // ------------------------------------------------------------
    localparam int RATE_MIN_MHZ = 10; // Lowest lockable pixel rate
    localparam int RATE_MAX_MHZ = 170; // Highest lockable pixel rate
    localparam int MCLK_MHZ = 50; // Register clock rate
endpackage

// file: common/odpc_lane_if.sv
// Interface between the register bank and the byte lane output stage
`timescale 1ns/1ps
interface odpc_lane_if #(
    parameter int LANES = 6,
    parameter int BYTE_W = 8
);
    logic [LANES*BYTE_W-1:0] din; // Formatted lane data
    logic [LANES-1:0] dis; // Per-lane three-state request
    logic [LANES*BYTE_W-1:0] dout; // Registered pin data
    logic [LANES*BYTE_W-1:0] oe; // Per-pin output enable
    modport ctrl (output din, output dis, input dout, input oe);
    modport lane (input din, input dis, output dout, output oe);
endinterface

// file: verilog/odpc_lanes.sv
// Byte lane output stage with per-lane three-state control
`timescale 1ns/1ps
module odpc_lanes #(
    parameter int LANES = 6,
    parameter int BYTE_W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    odpc_lane_if.lane lif
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    initial begin
        if (LANES < 1 || BYTE_W < 1) begin
            $error("odpc_lanes: LANES and BYTE_W must be positive");
        end
    end

    // ------------------------------------------------------------
    // Lane registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [BYTE_W-1:0] data_q; // Registered lane byte
            // Data flop per lane
            always_ff @(posedge mclk) begin
                if (rst) begin
                    data_q <= '0;
                end else begin
                    data_q <= lif.din[g*BYTE_W +: BYTE_W];
                end
            end
            assign lif.dout[g*BYTE_W +: BYTE_W] = data_q;
            assign lif.oe[g*BYTE_W +: BYTE_W] = {BYTE_W{~lif.dis[g]}};
        end
    endgenerate
endmodule

// file: verilog/odpc_top.sv
// Output disable and power control register bank with pin control
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module odpc_top #(
    parameter int PPL_W = odpc_pkg::PPL_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic fmt_wide,
    input wire logic [47:0] pix_in,
    output logic [47:0] pix_out,
    output logic [47:0] pix_oe,
    input wire logic pix_clk_in,
    output logic output_pixel_clock,
    output logic output_pixel_clock_oe,
    output logic red_pd,
    output logic green_pd,
    output logic blue_pd,
    output logic loop_pd,
    output logic [7:0] tuning,
    output logic [2:0] clamp_code,
    output logic clamp_on,
    output logic [5:0] phase_sel,
    output logic [PPL_W-1:0] pixels_per_line,
    output logic loop_run
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    initial begin
        if (PPL_W < 9 || PPL_W > 12) begin
            $error("odpc_top: PPL_W must lie in 9..12");
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] tristate_q; // Output disable bits
    logic [7:0] power_q; // Power-down bits
    logic [7:0] tuning_q; // Tuning byte
    logic [7:0] clamp_q; // Clamp impedance and reserved bits
    logic [7:0] ppl_lo_q; // Pixel count, low byte
    logic [7:0] ppl_hi_q; // Pixel count, high part
    logic [7:0] phase_q; // Phase select
    logic [7:0] rdata_q; // Read data register
    logic [7:0] rdata_d; // Read data next value
    logic [7:0] status; // Live block state
    logic pix_clk_q; // Registered pixel clock
    logic [47:0] lane_data; // Formatted lane data

    // Write decode helpers
    logic wr_ts;
    logic wr_pd;
    logic wr_tn;
    logic wr_cl;
    logic wr_pl;
    logic wr_ph;
    logic wr_ps;
    assign wr_ts = reg_wr && (reg_addr == odpc_pkg::OFS_TRISTATE);
    assign wr_pd = reg_wr && (reg_addr == odpc_pkg::OFS_POWER);
    assign wr_tn = reg_wr && (reg_addr == odpc_pkg::OFS_TUNING);
    assign wr_cl = reg_wr && (reg_addr == odpc_pkg::OFS_CLAMP);
    assign wr_pl = reg_wr && (reg_addr == odpc_pkg::OFS_PPL_LO);
    assign wr_ph = reg_wr && (reg_addr == odpc_pkg::OFS_PPL_HI);
    assign wr_ps = reg_wr && (reg_addr == odpc_pkg::OFS_PHASE);

    // ------------------------------------------------------------
    // Output configuration registers
    // ------------------------------------------------------------
    // Output disable register
    always_ff @(posedge mclk) begin
        // Default on reset, write acts next edge
        if (rst) begin
            tristate_q <= odpc_pkg::RST_TRISTATE;
        end else if (wr_ts) begin
            tristate_q <= reg_wdata;
        end
    end

    // Power-down register, reserved bits kept zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            power_q <= odpc_pkg::RST_POWER;
        end else if (wr_pd) begin
            power_q <= reg_wdata & odpc_pkg::PD_MASK;
        end
    end

    // Tuning register
    always_ff @(posedge mclk) begin
        if (rst) begin
            tuning_q <= odpc_pkg::RST_TUNING;
        end else if (wr_tn) begin
            tuning_q <= reg_wdata;
        end
    end

    // Clamp register, bit 7 reserved zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            clamp_q <= odpc_pkg::RST_CLAMP;
        end else if (wr_cl) begin
            clamp_q <= reg_wdata & odpc_pkg::CLAMP_MASK;
        end
    end

    // ------------------------------------------------------------
    // Sampling loop registers
    // ------------------------------------------------------------
    // Pixel count bytes
    always_ff @(posedge mclk) begin
        if (rst) begin
            ppl_lo_q <= odpc_pkg::RST_PPL_LO;
            ppl_hi_q <= odpc_pkg::RST_PPL_HI;
        end else begin
            if (wr_pl) begin
                ppl_lo_q <= reg_wdata;
            end
            if (wr_ph) begin
                ppl_hi_q <= reg_wdata & odpc_pkg::PPL_HI_MASK;
            end
        end
    end

    // Phase select
    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_q <= odpc_pkg::RST_PHASE;
        end else if (wr_ps) begin
            phase_q <= reg_wdata & odpc_pkg::PHASE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Controlled functions
    // ------------------------------------------------------------
    // Red converter power-down
    assign red_pd = power_q[odpc_pkg::PD_RED];
    assign green_pd = power_q[odpc_pkg::PD_GREEN];
    assign blue_pd = power_q[odpc_pkg::PD_BLUE];
    assign loop_pd = power_q[odpc_pkg::PD_LOOP];
    assign tuning = tuning_q;
    assign clamp_code = clamp_q[odpc_pkg::CLAMP_LSB +: odpc_pkg::CLAMP_W];
    assign clamp_on = (clamp_code != 3'h0);
    assign phase_sel = phase_q[odpc_pkg::PHASE_W-1:0];
    assign pixels_per_line = PPL_W'({ppl_hi_q[3:0], ppl_lo_q});
    // Loop runs once pixel count is nonzero and loop power-down bit 3 is clear
    assign loop_run = !loop_pd && (pixels_per_line != '0);

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    odpc_lane_if #(.LANES(odpc_pkg::LANES), .BYTE_W(odpc_pkg::BYTE_W)) lif ();

    // Narrow mode drives secondary lanes low
    always_comb begin
        lane_data = pix_in;
        if (!fmt_wide) begin
            lane_data[15:8] = 8'h00;
            lane_data[31:24] = 8'h00;
            lane_data[47:40] = 8'h00;
        end
    end
    assign lif.din = lane_data;
    // Lane disable bits, one per byte
    assign lif.dis = tristate_q[odpc_pkg::TS_LANE_LSB +: odpc_pkg::LANES];

    odpc_lanes #(.LANES(odpc_pkg::LANES), .BYTE_W(odpc_pkg::BYTE_W)) u_lanes (
        .mclk(mclk),
        .rst(rst),
        .lif(lif.lane)
    );
    assign pix_out = lif.dout;
    assign pix_oe = lif.oe;

    // Pixel clock register
    always_ff @(posedge mclk) begin
        if (rst) begin
            pix_clk_q <= 1'b0;
        end else begin
            pix_clk_q <= pix_clk_in;
        end
    end
    assign output_pixel_clock = pix_clk_q;
    // Either clock bit three-states the pin
    assign output_pixel_clock_oe =
        ~(tristate_q[odpc_pkg::TS_CLK_A] | tristate_q[odpc_pkg::TS_CLK_B]);

    // ------------------------------------------------------------
    // Status and read path
    // ------------------------------------------------------------
    // Live state word
    always_comb begin
        status = 8'h00;
        status[odpc_pkg::ST_LOOP_RUN] = loop_run;
        status[odpc_pkg::ST_CLAMP_ON] = clamp_on;
        status[odpc_pkg::ST_LANE_OFF] = |lif.dis;
        status[odpc_pkg::ST_CLK_OFF] = ~output_pixel_clock_oe;
    end

    // Read mux, unmapped reads return zero
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                odpc_pkg::OFS_TRISTATE: rdata_d = tristate_q;
                odpc_pkg::OFS_POWER: rdata_d = power_q;
                odpc_pkg::OFS_TUNING: rdata_d = tuning_q;
                odpc_pkg::OFS_CLAMP: rdata_d = clamp_q;
                odpc_pkg::OFS_PPL_LO: rdata_d = ppl_lo_q;
                odpc_pkg::OFS_PPL_HI: rdata_d = ppl_hi_q;
                odpc_pkg::OFS_PHASE: rdata_d = phase_q;
                odpc_pkg::OFS_STATUS: rdata_d = status;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Read data stands one cycle only
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    lane_oe_a:
    assert property (@(posedge mclk) disable iff (rst)
        wr_ts ##1 1'b1 |-> (pix_oe[23:16] == {8{~$past(reg_wdata[2])}})
            && (pix_oe[47:40] == {8{~$past(reg_wdata[5])}}))
    else $error("lane enable does not follow disable bit");

    clk_oe_a:
    assert property (@(posedge mclk) disable iff (rst)
        wr_ts |=> output_pixel_clock_oe == !($past(reg_wdata[6]) || $past(reg_wdata[7])))
    else $error("pixel clock enable wrong");

    disable_wins_a:
    assert property (@(posedge mclk) disable iff (rst)
        tristate_q[3] |-> pix_oe[31:24] == 8'h00)
    else $error("disabled lane still driven");

    red_pd_a:
    assert property (@(posedge mclk) disable iff (rst)
        wr_pd |=> red_pd == $past(reg_wdata[0]))
    else $error("red power-down wrong");

    green_pd_a:
    assert property (@(posedge mclk) disable iff (rst)
        wr_pd |=> green_pd == $past(reg_wdata[1]))
    else $error("green power-down wrong");

    blue_pd_a:
    assert property (@(posedge mclk) disable iff (rst)
        wr_pd |=> blue_pd == $past(reg_wdata[2]))
    else $error("blue power-down wrong");

    loop_pd_a:
    assert property (@(posedge mclk) disable iff (rst)
        wr_pd ##1 !wr_pd |=> loop_pd == $past(reg_wdata[3], 2) && (!loop_pd || !loop_run))
    else $error("loop power-down wrong");

    clamp_code_a:
    assert property (@(posedge mclk) disable iff (rst)
        wr_cl |=> clamp_code == $past(reg_wdata[6:4])
            && clamp_on == ($past(reg_wdata[6:4]) != 3'h0))
    else $error("clamp code wrong");

    reset_val_a:
    assert property (@(posedge mclk)
        rst |=> tuning_q == odpc_pkg::RST_TUNING && clamp_q == odpc_pkg::RST_CLAMP
            && power_q == odpc_pkg::RST_POWER && tristate_q == odpc_pkg::RST_TRISTATE)
    else $error("reset value wrong");

    read_once_a:
    assert property (@(posedge mclk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

    cv_tuning: cover property (@(posedge mclk) wr_tn && reg_wdata == odpc_pkg::TUNING_BEST);
    cv_all_off: cover property (@(posedge mclk) tristate_q == 8'hFF);
    cv_loop_run: cover property (@(posedge mclk) $rose(loop_run));
    cv_status_rd: cover property (@(posedge mclk) reg_rd && reg_addr == odpc_pkg::OFS_STATUS);
endmodule

// file: bench/odpc_tb.sv
// Self-checking bench for the output disable and power control bank
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Stimulus, outputs and bench state
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst = 1'b1; // Held for the first 16 cycles
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fmt_wide = 1'b1;
    logic [47:0] pix_in = 48'h000000000000;
    logic pix_clk_in = 1'b0;
    logic [7:0] reg_rdata, tuning;
    logic [47:0] pix_out, pix_oe;
    logic output_pixel_clock, output_pixel_clock_oe, red_pd, green_pd, blue_pd, loop_pd;
    logic clamp_on, loop_run;
    logic [2:0] clamp_code;
    logic [5:0] phase_sel;
    logic [11:0] pixels_per_line;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0; // Hang guard
    logic [7:0] rd_q[$]; // Expected read data, oldest first
    logic rd_seen = 1'b0; // Read taken at the last edge
    logic [7:0] sh_ts, sh_pd, sh_tun, sh_clamp, sh_lo, sh_hi, sh_ph; // Register shadows
    logic [31:0] seed_v;
    localparam logic [7:0] ADRS [10] = '{8'h1A, 8'h1B, 8'h1C, 8'h23, 8'h30, 8'h31,
                                         8'h32, 8'h33, 8'h00, 8'hFF}; // Mapped plus two holes

    odpc_top u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fmt_wide(fmt_wide),
        .pix_in(pix_in), .pix_out(pix_out), .pix_oe(pix_oe), .pix_clk_in(pix_clk_in),
        .output_pixel_clock(output_pixel_clock), .output_pixel_clock_oe(output_pixel_clock_oe),
        .red_pd(red_pd), .green_pd(green_pd), .blue_pd(blue_pd), .loop_pd(loop_pd),
        .tuning(tuning), .clamp_code(clamp_code), .clamp_on(clamp_on), .phase_sel(phase_sel),
        .pixels_per_line(pixels_per_line), .loop_run(loop_run));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Compare, report and expectation helpers
    // ------------------------------------------------------------
    task automatic cmp_rd(input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch reg_rdata expected %h seen %h", exp, got);
        end
    endtask

    task automatic cmp_pin(input string name, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("counts: compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic exp_run();
        return !sh_pd[3] && ({sh_hi[3:0], sh_lo} != 12'h000);
    endfunction

    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        case (a)
            odpc_pkg::OFS_TRISTATE: return sh_ts;
            odpc_pkg::OFS_POWER: return sh_pd;
            odpc_pkg::OFS_TUNING: return sh_tun;
            odpc_pkg::OFS_CLAMP: return sh_clamp;
            odpc_pkg::OFS_PPL_LO: return sh_lo;
            odpc_pkg::OFS_PPL_HI: return sh_hi;
            odpc_pkg::OFS_PHASE: return sh_ph;
            odpc_pkg::OFS_STATUS: return {4'h0, sh_ts[6] | sh_ts[7], |sh_ts[5:0],
                                          sh_clamp[6:4] != 3'h0, exp_run()};
            default: return 8'h00;
        endcase
    endfunction

    task automatic sh_reset();
        sh_ts = odpc_pkg::RST_TRISTATE;
        sh_pd = odpc_pkg::RST_POWER;
        sh_tun = odpc_pkg::RST_TUNING;
        sh_clamp = odpc_pkg::RST_CLAMP;
        sh_lo = odpc_pkg::RST_PPL_LO;
        sh_hi = odpc_pkg::RST_PPL_HI;
        sh_ph = odpc_pkg::RST_PHASE;
    endtask

    // ------------------------------------------------------------
    // Bus driver: one strobe per edge, idle releases both
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        case (a)
            odpc_pkg::OFS_TRISTATE: sh_ts = d;
            odpc_pkg::OFS_POWER: sh_pd = d & odpc_pkg::PD_MASK;
            odpc_pkg::OFS_TUNING: sh_tun = d;
            odpc_pkg::OFS_CLAMP: sh_clamp = d & odpc_pkg::CLAMP_MASK;
            odpc_pkg::OFS_PPL_LO: sh_lo = d;
            odpc_pkg::OFS_PPL_HI: sh_hi = d & odpc_pkg::PPL_HI_MASK;
            odpc_pkg::OFS_PHASE: sh_ph = d & odpc_pkg::PHASE_MASK;
            default: ;
        endcase
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a);
        rd_q.push_back(exp_reg(a));
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge mclk);
    endtask

    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic stim();
        fmt_wide <= 1'($urandom);
        pix_in <= 48'({$urandom, $urandom});
        pix_clk_in <= 1'($urandom);
    endtask

    // Port checks against the shadows, then a back-to-back readback sweep
    task automatic check();
        logic [47:0] oe_x;
        #1;
        for (int i = 0; i < 6; i++) oe_x[i*8 +: 8] = {8{~sh_ts[i]}};
        cmp_pin("pix_oe", oe_x, pix_oe);
        cmp_pin("pix_out", fmt_wide ? pix_in : (pix_in & 48'h00FF00FF00FF), pix_out);
        cmp_pin("clk_oe", 48'(!(sh_ts[6] || sh_ts[7])), 48'(output_pixel_clock_oe));
        cmp_pin("pix_clk", 48'(pix_clk_in), 48'(output_pixel_clock));
        cmp_pin("red_pd", 48'(sh_pd[0]), 48'(red_pd));
        cmp_pin("green_pd", 48'(sh_pd[1]), 48'(green_pd));
        cmp_pin("blue_pd", 48'(sh_pd[2]), 48'(blue_pd));
        cmp_pin("loop_pd", 48'(sh_pd[3]), 48'(loop_pd));
        cmp_pin("tuning", 48'(sh_tun), 48'(tuning));
        cmp_pin("clamp_code", 48'(sh_clamp[6:4]), 48'(clamp_code));
        cmp_pin("clamp_on", 48'(sh_clamp[6:4] != 3'h0), 48'(clamp_on));
        cmp_pin("phase_sel", 48'(sh_ph[5:0]), 48'(phase_sel));
        cmp_pin("ppl", 48'({sh_hi[3:0], sh_lo}), 48'(pixels_per_line));
        cmp_pin("loop_run", 48'(exp_run()), 48'(loop_run));
        for (int i = 0; i < 10; i++) rd(ADRS[i]);
        idle();
    endtask

    // ------------------------------------------------------------
    // Read data watcher: one answer cycle after each read, else 0
    // ------------------------------------------------------------
    always @(posedge mclk) rd_seen <= reg_rd;

    always @(negedge mclk) begin
        if (rd_seen) begin
            cmp_rd((rd_q.size() > 0) ? rd_q.pop_front() : 8'hXX, reg_rdata);
        end else begin
            cmp_rd(8'h00, reg_rdata);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed_v = $urandom(32'h34017d88);
        sh_reset();
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // Lane data settles into the pin flops at the first free edge
        stim();
        @(posedge mclk);
        check();
        $display("test reset_defaults done");
        // walk each disable bit, then random masks
        for (int i = 0; i < 16; i++) begin
            stim();
            wr(odpc_pkg::OFS_TRISTATE, (i < 8) ? 8'(1 << i) : 8'($urandom));
            idle();
            check();
        end
        $display("test output_disable done");
        // to every power code, reserved bits set at random
        for (int v = 0; v < 16; v++) begin
            wr(odpc_pkg::OFS_POWER, {4'($urandom), 4'(v)});
            idle();
            check();
        end
        $display("test power_down done");
        wr(odpc_pkg::OFS_TUNING, 8'($urandom));
        wr(odpc_pkg::OFS_TUNING, odpc_pkg::TUNING_BEST);
        idle();
        check();
        $display("test tuning done");
        // every clamp code with reserved bit 7 set at random
        for (int c = 0; c < 8; c++) begin
            wr(odpc_pkg::OFS_CLAMP, {1'($urandom), 3'(c), 4'($urandom)});
            idle();
            check();
        end
        $display("test clamp_code done");
        // phase upper limit and pixel count with loop on and off
        wr(odpc_pkg::OFS_PHASE, 8'hFF);
        wr(odpc_pkg::OFS_PPL_LO, 8'hFF);
        wr(odpc_pkg::OFS_PPL_HI, 8'hFF);
        wr(odpc_pkg::OFS_POWER, 8'h00);
        idle();
        check();
        wr(odpc_pkg::OFS_PHASE, 8'($urandom));
        wr(odpc_pkg::OFS_PPL_HI, 8'h00);
        wr(odpc_pkg::OFS_PPL_LO, 8'h00);
        idle();
        check();
        $display("test loop_setup done");
        // holes and status ignore writes; write then read at once
        wr(8'h00, 8'hFF);
        wr(odpc_pkg::OFS_STATUS, 8'hFF);
        wr(8'h24, 8'hFF);
        wr(odpc_pkg::OFS_TRISTATE, 8'hC3);
        rd(odpc_pkg::OFS_TRISTATE);
        wr(odpc_pkg::OFS_PPL_LO, 8'h01);
        rd(odpc_pkg::OFS_STATUS);
        idle();
        check();
        $display("test ignored_and_back_to_back done");
        rst <= 1'b1;
        idle();
        idle();
        rst <= 1'b0;
        sh_reset();
        idle();
        check();
        $display("test mid_run_reset done");
        test_done();
    end
endmodule
